// ===== gar_consts.svh
// constants of the gas alarm relay control block
// assumes a 20 MHz clock and gas readings in 0.1 % units
`ifndef GAR_CONSTS_SVH
`define GAR_CONSTS_SVH
// ==========================================
// timing
`define GAR_CLK_KHZ        20000
`define GAR_TICK_MS        100
`define GAR_HOLD_MS        6000
`define GAR_INHIBIT_MS     60000
`define GAR_IDLE_MS        300000
`define GAR_SLOW_MS        60000
`define GAR_FAST_MS        5000
`define GAR_HOLD_TICKS     (`GAR_HOLD_MS / `GAR_TICK_MS)
`define GAR_INHIBIT_TICKS  (`GAR_INHIBIT_MS / `GAR_TICK_MS)
`define GAR_IDLE_TICKS     (`GAR_IDLE_MS / `GAR_TICK_MS)
`define GAR_SLOW_TICKS     (`GAR_SLOW_MS / `GAR_TICK_MS)
`define GAR_FAST_TICKS     (`GAR_FAST_MS / `GAR_TICK_MS)
// ==========================================
// levels, 0.1 % units; GAR_PCT_FULL and GAR_PCT_HOLD in percent of the set point
`define GAR_PCT_FULL       24'h000064
`define GAR_PCT_HOLD       24'h00005a
`define GAR_BG_MIN         8'h0a
`define GAR_BG_MAX         8'h64
`define GAR_BG_DEF         8'h28
`define GAR_O2_MIN         8'h6e
`define GAR_O2_MAX         8'hf0
`define GAR_O2_LO_DEF      8'hbe
`define GAR_O2_HI_DEF      8'hdc
`define GAR_O2_NORM        16'h00d1
`define GAR_SP1_DEF        16'h00c8
`define GAR_SP2_DEF        16'h0190
// ==========================================
// register byte offsets
`define GAR_OFF_CFG        8'h00
`define GAR_OFF_BG         8'h04
`define GAR_OFF_O2LO       8'h08
`define GAR_OFF_O2HI       8'h0c
`define GAR_OFF_SP1        8'h10
`define GAR_OFF_SP2        8'h14
`define GAR_OFF_CMD        8'h18
`define GAR_OFF_STAT       8'h1c
`define GAR_OFF_MISS       8'h20
`define GAR_OFF_ISTAT      8'h24
`define GAR_OFF_IMASK      8'h28
// ==========================================
// field positions
`define GAR_CFG_LATCH      0
`define GAR_CFG_FS         2
`define GAR_CMD_MRST       0
`define GAR_CMD_FRST       1
`define GAR_EV_ALM         0
`define GAR_EV_MISS        2
`define GAR_EV_EXIT        3
`endif

// ===== gar_pkg.sv
// types of the gas alarm relay control block
// assumes gar_consts.svh for all numbers
package gar_pkg;
    typedef enum logic [2:0] {
        SC_NORMAL, SC_BGL, SC_BGH, SC_LATCH1,
        SC_LATCH2, SC_FS1, SC_FS2
    } gar_screen_e;
    typedef struct packed {
        logic menu;
        logic add;
        logic sub;
    } gar_btn_s;
    typedef struct packed {
        logic hasRelay;
        logic hasRadio;
        logic isOxygen;
    } gar_strap_s;
    typedef struct packed {
        logic [23:0]      pre;
        logic             pend;
        logic             wr;
        logic [7:0]       addr;
        logic             hready;
        logic [31:0]      hrdata;
        logic [1:0]       latch;
        logic [1:0]       fs;
        logic [7:0]       bg;
        logic [7:0]       o2Lo;
        logic [7:0]       o2Hi;
        logic [1:0][15:0] sp;
        logic [1:0]       alarm;
        logic [1:0]       relay;
        logic             menuOpen;
        gar_screen_e      screen;
        logic [7:0]       edit;
        logic [11:0]      holdCnt;
        logic [11:0]      idleCnt;
        logic [11:0]      inhCnt;
        logic [11:0]      rptCnt;
        logic             report;
        logic [15:0]      miss;
        logic [3:0]       istat;
        logic [3:0]       imask;
        logic             irq;
        gar_btn_s         btnPrev;
    } gar_state_s;
endpackage

// ===== gar_relay_ctrl.sv
// alarm relay control: two alarm channels, menu, radio rate, bus
// assumes synchronous inputs, one 20 MHz clock, AHB-Lite master
`timescale 1ns/1ps
`include "gar_consts.svh"
module gar_relay_ctrl #(
    parameter int TICK_CYCLES = `GAR_CLK_KHZ * `GAR_TICK_MS
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // ahb-lite slave
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output wire logic [31:0]           hrdata,
    output wire logic                  hreadyout,
    output wire logic                  hresp,
    // unit inputs
    input  wire logic [15:0]           gasLevel,
    input  wire gar_pkg::gar_btn_s     btn,
    input  wire gar_pkg::gar_strap_s   strap,
    input  wire logic                  manualReset,
    input  wire logic                  factoryReset,
    input  wire logic                  radioMiss,
    // unit outputs
    output wire logic [1:0]            alarmActive,
    output wire logic [1:0]            relayDrive,
    output wire logic                  reportReq,
    output wire logic                  menuOpen,
    output wire gar_pkg::gar_screen_e  screen,
    output wire logic [15:0]           missCount,
    output wire logic                  irq
);
    import gar_pkg::*;

    gar_state_s st_r;
    gar_state_s st_nxt;
    logic       tick;
    logic       inhib;
    gar_btn_s   press;
    logic       oxy;

    // ==========================================
    // helpers
    function automatic logic [7:0] clampV(logic [7:0] v,
        logic [7:0] lo, logic [7:0] hi);
        clampV = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    function automatic gar_screen_e nextScr(gar_screen_e s,
        gar_strap_s c);
        case (s)
            SC_NORMAL: nextScr = c.hasRadio ? SC_BGL : SC_LATCH1;
            SC_BGL:    nextScr = c.isOxygen ? SC_BGH : SC_LATCH1;
            SC_BGH:    nextScr = SC_LATCH1;
            SC_LATCH1: nextScr = SC_LATCH2;
            SC_LATCH2: nextScr = c.hasRelay ? SC_FS1 : SC_NORMAL;
            SC_FS1:    nextScr = SC_FS2;
            default:   nextScr = SC_NORMAL;
        endcase
    endfunction

    function automatic logic [7:0] scrVal(gar_screen_e s,
        gar_state_s c, logic o);
        case (s)
            SC_BGL:    scrVal = o ? c.o2Lo : c.bg;
            SC_BGH:    scrVal = c.o2Hi;
            SC_LATCH1: scrVal = {7'h00, c.latch[0]};
            SC_LATCH2: scrVal = {7'h00, c.latch[1]};
            SC_FS1:    scrVal = {7'h00, c.fs[0]};
            SC_FS2:    scrVal = {7'h00, c.fs[1]};
            default:   scrVal = 8'h00;
        endcase
    endfunction

    function automatic logic [31:0] rdReg(gar_state_s c);
        rdReg = 32'h00000000;
        case (c.addr)
            `GAR_OFF_CFG:   rdReg[3:0] = {c.fs, c.latch};
            `GAR_OFF_BG:    rdReg[7:0] = c.bg;
            `GAR_OFF_O2LO:  rdReg[7:0] = c.o2Lo;
            `GAR_OFF_O2HI:  rdReg[7:0] = c.o2Hi;
            `GAR_OFF_SP1:   rdReg[15:0] = c.sp[0];
            `GAR_OFF_SP2:   rdReg[15:0] = c.sp[1];
            `GAR_OFF_STAT:  rdReg[7:0] = {1'b0, c.screen,
                c.inhCnt != 12'h000, c.menuOpen, c.alarm};
            `GAR_OFF_MISS:  rdReg[15:0] = c.miss;
            `GAR_OFF_ISTAT: rdReg[3:0] = c.istat;
            `GAR_OFF_IMASK: rdReg[3:0] = c.imask;
            default:        rdReg = 32'h00000000;
        endcase
    endfunction

    assign tick  = st_r.pre == 24'(TICK_CYCLES - 1);
    assign inhib = st_r.menuOpen | (st_r.inhCnt != 12'h000);
    assign press = btn & ~st_r.btnPrev;
    assign oxy   = strap.isOxygen;

    // ==========================================
    // next state
    always_comb
    begin
        logic       mrst;
        logic       frst;
        logic       fast;
        logic       exitM;
        logic [3:0] ev;
        logic [3:0] clr;
        logic [7:0] lo;
        logic [7:0] hi;
        logic [7:0] e;
        mrst  = manualReset;
        frst  = factoryReset;
        fast  = 1'b0;
        exitM = 1'b0;
        ev    = 4'h0;
        clr   = 4'h0;
        lo    = `GAR_BG_MIN;
        hi    = `GAR_BG_MAX;
        e     = st_r.edit;
        st_nxt = st_r;
        st_nxt.pre = tick ? 24'h000000 : st_r.pre + 24'h000001;
        st_nxt.btnPrev = btn;
        st_nxt.report = 1'b0;
        // bus slave, one wait state
        if (st_r.pend)
        begin
            st_nxt.pend = 1'b0;
            st_nxt.hready = 1'b1;
            if (!st_r.wr)
                st_nxt.hrdata = rdReg(st_r);
            else
                case (st_r.addr)
                    `GAR_OFF_CFG:
                    begin
                        st_nxt.latch = hwdata[`GAR_CFG_LATCH +: 2];
                        st_nxt.fs = hwdata[`GAR_CFG_FS +: 2];
                    end
                    `GAR_OFF_BG:    st_nxt.bg = clampV(hwdata[7:0],
                        `GAR_BG_MIN, `GAR_BG_MAX);
                    `GAR_OFF_O2LO:  st_nxt.o2Lo = clampV(hwdata[7:0],
                        `GAR_O2_MIN, `GAR_O2_MAX);
                    `GAR_OFF_O2HI:  st_nxt.o2Hi = clampV(hwdata[7:0],
                        `GAR_O2_MIN, `GAR_O2_MAX);
                    `GAR_OFF_SP1:   st_nxt.sp[0] = hwdata[15:0];
                    `GAR_OFF_SP2:   st_nxt.sp[1] = hwdata[15:0];
                    `GAR_OFF_CMD:
                    begin
                        mrst = mrst | hwdata[`GAR_CMD_MRST];
                        frst = frst | hwdata[`GAR_CMD_FRST];
                    end
                    `GAR_OFF_ISTAT: clr = hwdata[3:0];
                    `GAR_OFF_IMASK: st_nxt.imask = hwdata[3:0];
                    default: ;
                endcase
        end
        if (hsel && htrans[1] && hready)
        begin
            st_nxt.pend = 1'b1;
            st_nxt.wr = hwrite;
            st_nxt.addr = haddr[7:0];
            st_nxt.hready = 1'b0;
        end
        // alarm channels
        for (int i = 0; i < 2; i++)
        begin
            if (inhib)
                st_nxt.alarm[i] = 1'b0;
            else if (gasLevel >= st_r.sp[i])
                st_nxt.alarm[i] = 1'b1;
            else if (!st_r.latch[i])
            begin
                if (24'(gasLevel) * `GAR_PCT_FULL <=
                    24'(st_r.sp[i]) * `GAR_PCT_HOLD)
                    st_nxt.alarm[i] = 1'b0;
            end
            else if (mrst)
                st_nxt.alarm[i] = 1'b0;
            ev[`GAR_EV_ALM + i] = st_nxt.alarm[i] & ~st_r.alarm[i];
        end
        // menu
        if (!st_r.menuOpen)
        begin
            if (!btn.menu)
                st_nxt.holdCnt = 12'h000;
            else if (st_r.holdCnt >= 12'(`GAR_HOLD_TICKS))
            begin
                st_nxt.holdCnt = 12'h000;
                st_nxt.menuOpen = 1'b1;
                st_nxt.idleCnt = 12'h000;
                st_nxt.screen = nextScr(SC_NORMAL, strap);
                st_nxt.edit = scrVal(st_nxt.screen, st_r, oxy);
            end
            else if (tick)
                st_nxt.holdCnt = st_r.holdCnt + 12'h001;
        end
        else
        begin
            if (press != 3'b000)
                st_nxt.idleCnt = 12'h000;
            else if (st_r.idleCnt >= 12'(`GAR_IDLE_TICKS))
                exitM = 1'b1;
            else if (tick)
                st_nxt.idleCnt = st_r.idleCnt + 12'h001;
            if (st_r.screen == SC_BGL && oxy || st_r.screen == SC_BGH)
            begin
                lo = `GAR_O2_MIN;
                hi = `GAR_O2_MAX;
            end
            case (st_r.screen)
                SC_BGL, SC_BGH:
                    if (press.add && e < hi)
                        e = e + 8'h01;
                    else if (press.sub && e > lo)
                        e = e - 8'h01;
                SC_LATCH1, SC_LATCH2:
                    if (press.add || press.sub)
                        e = {7'h00, ~e[0]};
                default:
                    if (press.add)
                        e = 8'h01;
                    else if (press.sub)
                        e = 8'h00;
            endcase
            st_nxt.edit = e;
            if (press.menu)
            begin
                case (st_r.screen)
                    SC_BGL:
                        if (oxy)
                            st_nxt.o2Lo = e;
                        else
                            st_nxt.bg = e;
                    SC_BGH:    st_nxt.o2Hi = e;
                    SC_LATCH1: st_nxt.latch[0] = e[0];
                    SC_LATCH2: st_nxt.latch[1] = e[0];
                    SC_FS1:    st_nxt.fs[0] = e[0];
                    SC_FS2:    st_nxt.fs[1] = e[0];
                    default: ;
                endcase
                st_nxt.screen = nextScr(st_r.screen, strap);
                st_nxt.edit = scrVal(st_nxt.screen, st_nxt, oxy);
                if (st_nxt.screen == SC_NORMAL)
                    exitM = 1'b1;
            end
            if (exitM)
            begin
                st_nxt.menuOpen = 1'b0;
                st_nxt.screen = SC_NORMAL;
                st_nxt.inhCnt = 12'(`GAR_INHIBIT_TICKS);
                ev[`GAR_EV_EXIT] = 1'b1;
            end
        end
        if (!exitM && tick && st_r.inhCnt != 12'h000)
            st_nxt.inhCnt = st_r.inhCnt - 12'h001;
        // factory defaults
        if (frst)
        begin
            st_nxt.latch = 2'b00;
            st_nxt.fs = 2'b00;
            st_nxt.bg = `GAR_BG_DEF;
            st_nxt.o2Lo = `GAR_O2_LO_DEF;
            st_nxt.o2Hi = `GAR_O2_HI_DEF;
            st_nxt.miss = 16'h0000;
        end
        // radio report rate
        if (oxy)
            fast = (gasLevel < `GAR_O2_NORM &&
                    gasLevel <= {8'h00, st_r.o2Lo}) ||
                   (gasLevel > `GAR_O2_NORM &&
                    gasLevel >= {8'h00, st_r.o2Hi});
        else
            fast = gasLevel >= {8'h00, st_r.bg};
        if (!strap.hasRadio)
            st_nxt.rptCnt = 12'h000;
        else if (tick)
        begin
            if (st_r.rptCnt + 12'h001 >= (fast ?
                12'(`GAR_FAST_TICKS) : 12'(`GAR_SLOW_TICKS)))
            begin
                st_nxt.rptCnt = 12'h000;
                st_nxt.report = 1'b1;
            end
            else
                st_nxt.rptCnt = st_r.rptCnt + 12'h001;
        end
        // missed transmissions
        if (radioMiss && strap.hasRadio && !frst)
        begin
            ev[`GAR_EV_MISS] = 1'b1;
            if (st_r.miss != 16'hffff)
                st_nxt.miss = st_r.miss + 16'h0001;
        end
        // interrupts, set wins over clear
        st_nxt.istat = (st_r.istat & ~clr) | ev;
        st_nxt.irq = |(st_nxt.istat & st_nxt.imask);
        st_nxt.relay = st_nxt.alarm ^ st_nxt.fs;
    end

    // ==========================================
    // state register
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_r <= '0;
            st_r.hready <= 1'b1;
            st_r.bg <= `GAR_BG_DEF;
            st_r.o2Lo <= `GAR_O2_LO_DEF;
            st_r.o2Hi <= `GAR_O2_HI_DEF;
            st_r.sp[0] <= `GAR_SP1_DEF;
            st_r.sp[1] <= `GAR_SP2_DEF;
        end
        else
            st_r <= st_nxt;
    end

    assign hrdata      = st_r.hrdata;
    assign hreadyout   = st_r.hready;
    assign hresp       = 1'b0;
    assign alarmActive = st_r.alarm;
    assign relayDrive  = st_r.relay;
    assign reportReq   = st_r.report;
    assign menuOpen    = st_r.menuOpen;
    assign screen      = st_r.screen;
    assign missCount   = st_r.miss;
    assign irq         = st_r.irq;

    // ==========================================
    // checks
    generate
        for (genvar g = 0; g < 2; g++)
        begin : gCh
            alarm_on_a: assert property (
                @(posedge clk) disable iff (rst)
                (!inhib && gasLevel >= st_r.sp[g]) |=> st_r.alarm[g])
            else $error("alarm did not activate");
            auto_hold_a: assert property (
                @(posedge clk) disable iff (rst)
                (!inhib && st_r.alarm[g] && !st_r.latch[g] &&
                 24'(gasLevel) * `GAR_PCT_FULL >
                 24'(st_r.sp[g]) * `GAR_PCT_HOLD) |=> st_r.alarm[g])
            else $error("auto alarm dropped too early");
            latch_hold_a: assert property (
                @(posedge clk) disable iff (rst)
                (!inhib && st_r.alarm[g] && st_r.latch[g] &&
                 !manualReset && !st_r.pend) |=> st_r.alarm[g])
            else $error("latched alarm dropped");
            latch_clear_a: assert property (
                @(posedge clk) disable iff (rst)
                (!inhib && st_r.latch[g] && manualReset &&
                 gasLevel < st_r.sp[g]) |=> !st_r.alarm[g])
            else $error("manual reset ignored");
            fail_safe_a: assert property (
                @(posedge clk) disable iff (rst)
                relayDrive[g] == (alarmActive[g] ^ st_r.fs[g]))
            else $error("relay drive wrong");
        end
    endgenerate

    reset_default_a: assert property (
        @(posedge clk) rst |=> (st_r.latch == 2'b00 &&
        st_r.fs == 2'b00 && st_r.bg == `GAR_BG_DEF))
    else $error("bad defaults after reset");
    exit_inhibit_a: assert property (
        @(posedge clk) disable iff (rst)
        $fell(st_r.menuOpen) |->
        (st_r.inhCnt == 12'(`GAR_INHIBIT_TICKS) && st_r.alarm == 2'b00))
    else $error("inhibit not started");
    bg_range_a: assert property (
        @(posedge clk) disable iff (rst)
        st_r.bg >= `GAR_BG_MIN && st_r.bg <= `GAR_BG_MAX)
    else $error("background out of range");
    o2_range_a: assert property (
        @(posedge clk) disable iff (rst)
        st_r.o2Lo >= `GAR_O2_MIN && st_r.o2Hi <= `GAR_O2_MAX)
    else $error("oxygen threshold out of range");
    miss_count_a: assert property (
        @(posedge clk) disable iff (rst)
        (radioMiss && strap.hasRadio && !factoryReset && !st_r.pend &&
         st_r.miss != 16'hffff) |=> st_r.miss == $past(st_r.miss) + 16'h0001)
    else $error("miss not counted");
    menu_open_a: assert property (
        @(posedge clk) disable iff (rst)
        $rose(st_r.menuOpen) |-> $past(btn.menu, 1) && $past(btn.menu, 2))
    else $error("menu opened without hold");
endmodule

// ===== gar_far_side.sv
// far side: radio controller for reports and lost frames
// assumes the clock and reset of the block under test
`timescale 1ns/1ps
module gar_far_side (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // block side
    input  wire logic reportReq,
    output logic      radioMiss = 1'b0,
    // bench side
    input  wire logic missReq,
    output int        reports,
    output int        gap
);
    int age;
    // ==========================================
    // report arrivals and their spacing
    always @(posedge clk)
    begin
        age <= age + 1;
        radioMiss <= missReq; // lost frame, one pulse each
        if (rst)
        begin
            reports <= 0;
            age <= 0;
        end
        else if (reportReq)
        begin
            reports <= reports + 1; // report cadence
            gap <= age + 1;
            age <= 0;
        end
    end
endmodule

// ===== gas_alarm_relay_control_test.sv
// self-checking bench of the gas alarm relay control block
// assumes gar_far_side as radio controller
`timescale 1ns/1ps
`include "gar_consts.svh"
module gas_alarm_relay_control_test;
    import gar_pkg::*;
    localparam int TICK = 10;
    typedef struct packed {
        logic        wr;
        logic [7:0]  addr;
        logic [31:0] data;
        logic [31:0] exp;
    } gar_row_s;
    localparam gar_row_s ROWS [13] = '{
        '{1'b0, `GAR_OFF_CFG, 32'h0, 32'h0},
        '{1'b0, `GAR_OFF_BG, 32'h0, 32'h28},
        '{1'b0, `GAR_OFF_O2LO, 32'h0, 32'hbe},
        '{1'b0, `GAR_OFF_O2HI, 32'h0, 32'hdc},
        '{1'b0, `GAR_OFF_SP1, 32'h0, 32'hc8},
        '{1'b0, `GAR_OFF_MISS, 32'h0, 32'h0},
        '{1'b1, `GAR_OFF_BG, 32'h0, 32'h0a},
        '{1'b1, `GAR_OFF_BG, 32'hff, 32'h64},
        '{1'b1, `GAR_OFF_O2LO, 32'h0, 32'h6e},
        '{1'b1, `GAR_OFF_O2HI, 32'hff, 32'hf0},
        '{1'b1, 8'h30, 32'h5, 32'h0},
        '{1'b1, `GAR_OFF_IMASK, 32'h1, 32'h1},
        '{1'b1, `GAR_OFF_BG, 32'h28, 32'h28}};
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [15:0] gasLevel = 16'h0;
    gar_btn_s    btn = 3'h0;
    gar_strap_s  strap = 3'h6;
    logic        manualReset = 1'b0;
    logic        factoryReset = 1'b0;
    logic        missReq = 1'b0;
    logic        radioMiss;
    logic        hreadyout;
    logic        hresp;
    logic        reportReq;
    logic        menuOpen;
    logic        irq;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic [1:0]  alarmActive;
    logic [1:0]  relayDrive;
    gar_screen_e screen;
    logic [15:0] missCount;
    int          reports;
    int          gap;
    int          fail_count = 0;
    int          checked = 0;
    int          n;
    always #25 clk = ~clk;
    gar_relay_ctrl #(.TICK_CYCLES(TICK)) dut_u (.clk(clk), .rst(rst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .gasLevel(gasLevel),
        .btn(btn),
        .strap(strap), .manualReset(manualReset),
        .factoryReset(factoryReset), .radioMiss(radioMiss),
        .alarmActive(alarmActive), .relayDrive(relayDrive),
        .reportReq(reportReq), .menuOpen(menuOpen), .screen(screen),
        .missCount(missCount), .irq(irq));
    gar_far_side far_u (.clk(clk), .rst(rst), .reportReq(reportReq),
        .radioMiss(radioMiss), .missReq(missReq), .reports(reports),
        .gap(gap));
    // ==========================================
    // checking and closing
    task close_out;
        if (fail_count == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input string what, input logic [31:0] seen,
             input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task stuck;
        fail_count++;
        $display("BAD wait exp done seen timeout");
        close_out;
    endtask
    task tick(input int c);
        repeat (c) @(posedge clk);
    endtask
    // ==========================================
    // bus, buttons and waits
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        n = 0;
        @(posedge clk);
        while (hreadyout !== 1'b1 && n++ < 50)
            @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1 && n++ < 50)
            @(posedge clk);
        rd = hrdata;
        if (n >= 50)
            stuck;
    endtask
    task tap(input logic [2:0] b);
        @(posedge clk);
        btn <= b;
        @(posedge clk);
        btn <= 3'h0;
        tick(3);
    endtask
    task waitrep(input int k);
        n = reports + k;
        for (int i = 0; i < 20000 && reports < n; i++)
            @(posedge clk);
        if (reports < n)
            stuck;
    endtask
    task openMenu;
        @(posedge clk);
        btn <= 3'h4;
        n = 0;
        while (menuOpen !== 1'b1 && n++ < 1000)
            @(posedge clk);
        btn <= 3'h0;
        chk("hold", 32'(n > 570 && n < 630), 1);
    endtask
    // ==========================================
    // main sequence
    initial
    begin
        tick(10);
        rst <= 1'b0;
        chk("reset", 32'({alarmActive, relayDrive, hreadyout}), 1);
        foreach (ROWS[k])
        begin
            if (ROWS[k].wr)
                bus(1'b1, ROWS[k].addr, ROWS[k].data);
            bus(1'b0, ROWS[k].addr, 32'h0);
            chk("register", rd, ROWS[k].exp);
            chk("okay resp", 32'(hresp), 0);
        end
        repeat (3)
        begin
            @(posedge clk);
            missReq <= 1'b1;
            @(posedge clk);
            missReq <= 1'b0;
        end
        tick(4);
        chk("miss count", 32'(missCount), 3);
        chk("masked irq", 32'(irq), 0);
        waitrep(2);
        chk("slow rate", gap, `GAR_SLOW_TICKS * TICK);
        gasLevel <= 16'h0028;
        waitrep(2);
        chk("fast rate", gap, `GAR_FAST_TICKS * TICK);
        gasLevel <= 16'h00c7;
        tick(5);
        chk("below sp", 32'(alarmActive), 0);
        gasLevel <= 16'h0190;
        tick(5);
        chk("at sp", 32'(alarmActive), 3);
        chk("irq", 32'(irq), 1);
        gasLevel <= 16'h0169;
        tick(5);
        chk("hysteresis", 32'(alarmActive), 3);
        gasLevel <= 16'h0168;
        tick(5);
        chk("auto clear", 32'(alarmActive), 1);
        bus(1'b1, `GAR_OFF_ISTAT, 32'h1);
        bus(1'b0, `GAR_OFF_ISTAT, 32'h0);
        chk("status", rd, 32'h6);
        chk("irq clear", 32'(irq), 0);
        gasLevel <= 16'h01f4;
        openMenu;
        chk("screen", 32'(screen), 32'(SC_BGL));
        tap(3'h4);
        chk("screen", 32'(screen), 32'(SC_LATCH1));
        tap(3'h2);
        tap(3'h4);
        chk("screen", 32'(screen), 32'(SC_LATCH2));
        tap(3'h4);
        chk("screen", 32'(screen), 32'(SC_FS1));
        tap(3'h2);
        tap(3'h4);
        chk("menu alarm", 32'(alarmActive), 0);
        tap(3'h4);
        chk("menu exit", 32'(menuOpen), 0);
        bus(1'b0, `GAR_OFF_CFG, 32'h0);
        chk("config", rd, 32'h5);
        chk("fail-safe idle", 32'(relayDrive), 1);
        tick(`GAR_INHIBIT_TICKS * TICK - 300);
        chk("inhibit", 32'(alarmActive), 0);
        n = 0;
        while (alarmActive !== 2'h3 && n++ < 600)
            @(posedge clk);
        chk("fail-safe alarm", 32'(relayDrive), 2);
        gasLevel <= 16'h0000;
        tick(5);
        chk("latched", 32'(alarmActive), 1);
        gasLevel <= 16'h00fa;
        @(posedge clk);
        manualReset <= 1'b1;
        @(posedge clk);
        manualReset <= 1'b0;
        tick(5);
        chk("reset refused", 32'(alarmActive), 1);
        gasLevel <= 16'h0064;
        @(posedge clk);
        manualReset <= 1'b1;
        @(posedge clk);
        manualReset <= 1'b0;
        tick(5);
        chk("reset taken", 32'(alarmActive), 0);
        openMenu;
        n = 0;
        while (menuOpen !== 1'b0 && n++ < 31000)
            @(posedge clk);
        chk("idle exit", 32'(n > 29900 && n < 30100), 1);
        @(posedge clk);
        factoryReset <= 1'b1;
        @(posedge clk);
        factoryReset <= 1'b0;
        bus(1'b0, `GAR_OFF_CFG, 32'h0);
        chk("defaults", rd, 32'h0);
        close_out;
    end
    initial
    begin
        tick(100000);
        stuck;
    end
endmodule
